// ---- hw/spkdg_defines.svh ----
`ifndef SPKDG_DEFINES_SVH
`define SPKDG_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SPKDG_OFS_DSP_CFG      16'h2092
`define SPKDG_OFS_SPREAD       16'h2093
`define SPKDG_OFS_THRESH       16'h2094
`define SPKDG_OFS_HEADROOM     16'h2095
`define SPKDG_OFS_HOLD         16'h2096
`define SPKDG_OFS_DELAY        16'h2097
`define SPKDG_OFS_MODE         16'h2098
`define SPKDG_OFS_VBAT_LVL     16'h2099
`define SPKDG_OFS_FSW          16'h209a
`define SPKDG_OFS_WB_ONLY      16'h209b
`define SPKDG_OFS_EDGE1        16'h209c
`define SPKDG_OFS_EDGE2        16'h209d
`define SPKDG_OFS_CLIP         16'h209e
`define SPKDG_OFS_VOLUME       16'h2090

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SPKDG_RST_DSP_CFG      8'h23
`define SPKDG_RST_SPREAD       8'h08
`define SPKDG_RST_THRESH       8'h12
`define SPKDG_RST_HEADROOM     8'h17
`define SPKDG_RST_HOLD         8'h17
`define SPKDG_RST_DELAY        8'h00
`define SPKDG_RST_MODE         8'h00
`define SPKDG_RST_VBAT_LVL     8'h03
`define SPKDG_RST_FSW          8'h00
`define SPKDG_RST_WB_ONLY      8'h00
`define SPKDG_RST_EDGE1        8'h03
`define SPKDG_RST_EDGE2        8'hfc
`define SPKDG_RST_CLIP         8'h00
`define SPKDG_RST_VOLUME       8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SPKDG_BIT_DCBLK        0
`define SPKDG_BIT_DITHER       1
`define SPKDG_BIT_INVERT       2
`define SPKDG_BIT_RAMPUP_SKIP  3
`define SPKDG_BIT_RAMPDN_SKIP  4
`define SPKDG_BIT_PROTECT      5
`define SPKDG_BIT_WIDE_PASS    6
`define SPKDG_BIT_SPREAD_ON    3
`define SPKDG_BIT_FSW2X        2
`define SPKDG_BIT_SLEW         7

// ----------------------------------------------------------------
// decode limits and steps (millivolts for the voltage entries)
// ----------------------------------------------------------------
`define SPKDG_THR_TOP_MV       13'd3800
`define SPKDG_THR_STEP_MV      13'd100
`define SPKDG_HEAD_STEP_MV     13'd250
`define SPKDG_FLOOR_BASE_MV    13'd2500
`define SPKDG_FLOOR_STEP_MV    13'd100
`define SPKDG_FLOOR_MAX_CODE   3'h5
`define SPKDG_DELAY_MAX        6'h20
`define SPKDG_VOL_RSV_LO       8'hb5
`define SPKDG_VOL_MUTE         8'hff
`define SPKDG_CLIP_MAX_CODE    4'ha
`define SPKDG_RSV_2BIT         2'h3
`define SPKDG_PROTECT_SHIFT    3
`define SPKDG_VOL_PER_6DB      8'd12
`define SPKDG_CLK_MHZ          10
`define SPKDG_DC_SHIFT         8

`endif

// ---- hw/spkdg_pkg.sv ----
`default_nettype none
package spkdg_pkg;

   // configuration seen by the analog and filter blocks
   typedef struct packed {
      logic       wide_passband_on;
      logic       spread_clock_on;
      logic [1:0] spread_index;
      logic       double_switch_rate;
      logic       ultrasound_only_on;
      logic       turnoff_slew_on;
      logic [3:0] battery_high_side_edge;
      logic [3:0] low_side_edge;
      logic [3:0] high_rail_edge;
      logic [3:0] clip_boost;
   } spkdg_ctrl_type;

   typedef enum logic [1:0] {
      SUP_PVDD,
      SUP_HOLD,
      SUP_VBAT
   } spkdg_sup_type;

endpackage
`default_nettype wire

// ---- hw/spkdg_top.sv ----
`include "spkdg_defines.svh"
`default_nettype none
module spkdg_top #(
   parameter int AW         = 24,
   parameter int HOLD_SHIFT = 0,
   parameter int DLY_DEPTH  = 33
) (
   input  wire logic                    CLK_SYS,
   input  wire logic                    RESET_N,
   input  wire logic [15:0]             REG_ADDR,
   input  wire logic                    REG_WR,
   input  wire logic                    REG_RD,
   input  wire logic [7:0]              REG_WDATA,
   output logic      [7:0]              REG_RDATA,
   output logic                         REG_RVALID,
   input  wire logic                    AMP_ENABLE,
   input  wire logic                    SAMPLE_STROBE,
   input  wire logic signed [AW-1:0]    PCM_SAMPLE,
   input  wire logic signed [AW-1:0]    WIDEBAND_SAMPLE,
   input  wire logic [12:0]             PEAK_MV,
   input  wire logic [12:0]             VBAT_MV,
   output logic signed [AW-1:0]         AUDIO_OUT,
   output logic                         AUDIO_OUT_VALID,
   output logic                         SUPPLY_VBAT,
   output spkdg_pkg::spkdg_ctrl_type    AMP_CTRL
);

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [7:0] dsp_r, spread_r, thr_r, head_r, hold_r, dly_r, mode_r;
   logic [7:0] vlvl_r, fsw_r, wb_r, edge1_r, edge2_r, clip_r, vol_r;
   logic [7:0] rdata_r;
   logic       rvalid_r;

   // write decode per register
   wire wr_dsp   = REG_WR && (REG_ADDR == `SPKDG_OFS_DSP_CFG);
   wire wr_spr   = REG_WR && (REG_ADDR == `SPKDG_OFS_SPREAD);
   wire wr_thr   = REG_WR && (REG_ADDR == `SPKDG_OFS_THRESH);
   wire wr_head  = REG_WR && (REG_ADDR == `SPKDG_OFS_HEADROOM);
   wire wr_hold  = REG_WR && (REG_ADDR == `SPKDG_OFS_HOLD);
   wire wr_dly   = REG_WR && (REG_ADDR == `SPKDG_OFS_DELAY);
   wire wr_mode  = REG_WR && (REG_ADDR == `SPKDG_OFS_MODE);
   wire wr_vlvl  = REG_WR && (REG_ADDR == `SPKDG_OFS_VBAT_LVL);
   wire wr_fsw   = REG_WR && (REG_ADDR == `SPKDG_OFS_FSW);
   wire wr_wb    = REG_WR && (REG_ADDR == `SPKDG_OFS_WB_ONLY);
   wire wr_edge1 = REG_WR && (REG_ADDR == `SPKDG_OFS_EDGE1);
   wire wr_edge2 = REG_WR && (REG_ADDR == `SPKDG_OFS_EDGE2);
   wire wr_clip  = REG_WR && (REG_ADDR == `SPKDG_OFS_CLIP);
   wire wr_vol   = REG_WR && (REG_ADDR == `SPKDG_OFS_VOLUME);

   // reserved-code screens: a rejected field keeps its old value
   wire sel_ok   = (REG_WDATA[5:4] != `SPKDG_RSV_2BIT);
   wire mode_ok  = (REG_WDATA[1:0] != `SPKDG_RSV_2BIT);
   wire vlvl_ok  = (REG_WDATA[2:0] <= `SPKDG_FLOOR_MAX_CODE);
   wire dly_ok   = (REG_WDATA[5:0] <= `SPKDG_DELAY_MAX);
   wire clip_ok  = (REG_WDATA[3:0] <= `SPKDG_CLIP_MAX_CODE);
   wire vol_ok   = (REG_WDATA < `SPKDG_VOL_RSV_LO) || (REG_WDATA == `SPKDG_VOL_MUTE);
   wire [1:0] head_sel_nxt = sel_ok ? REG_WDATA[5:4] : head_r[5:4];

   // register writes; unused bits are stored as zero
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         dsp_r    <= `SPKDG_RST_DSP_CFG;
         spread_r <= `SPKDG_RST_SPREAD;
         thr_r    <= `SPKDG_RST_THRESH;
         head_r   <= `SPKDG_RST_HEADROOM;
         hold_r   <= `SPKDG_RST_HOLD;
         dly_r    <= `SPKDG_RST_DELAY;
         mode_r   <= `SPKDG_RST_MODE;
         vlvl_r   <= `SPKDG_RST_VBAT_LVL;
         fsw_r    <= `SPKDG_RST_FSW;
         wb_r     <= `SPKDG_RST_WB_ONLY;
         edge1_r  <= `SPKDG_RST_EDGE1;
         edge2_r  <= `SPKDG_RST_EDGE2;
         clip_r   <= `SPKDG_RST_CLIP;
         vol_r    <= `SPKDG_RST_VOLUME;
      end else begin
         if (wr_dsp)   dsp_r    <= {1'b0, REG_WDATA[6:0]};
         if (wr_spr)   spread_r <= {4'h0, REG_WDATA[3], 1'b0, REG_WDATA[1:0]};
         if (wr_thr)   thr_r    <= {3'h0, REG_WDATA[4:0]};
         if (wr_head)  head_r   <= {2'h0, head_sel_nxt, REG_WDATA[3:0]};
         if (wr_hold)  hold_r   <= {1'b0, REG_WDATA[6:0]};
         if (wr_dly && dly_ok)   dly_r  <= {2'h0, REG_WDATA[5:0]};
         if (wr_mode && mode_ok) mode_r <= {6'h00, REG_WDATA[1:0]};
         if (wr_vlvl && vlvl_ok) vlvl_r <= {5'h00, REG_WDATA[2:0]};
         if (wr_fsw)   fsw_r    <= {5'h00, REG_WDATA[2], 2'h0};
         if (wr_wb)    wb_r     <= {7'h00, REG_WDATA[0]};
         if (wr_edge1) edge1_r  <= {REG_WDATA[7], 3'h0, REG_WDATA[3:0]};
         if (wr_edge2) edge2_r  <= REG_WDATA;
         if (wr_clip && clip_ok) clip_r <= {4'h0, REG_WDATA[3:0]};
         if (wr_vol && vol_ok)   vol_r  <= REG_WDATA;
      end
   end

   // ----------------------------------------------------------------
   // read back
   // ----------------------------------------------------------------
   logic [7:0] rd_mux;
   always_comb begin
      case (REG_ADDR)
         `SPKDG_OFS_DSP_CFG:  rd_mux = dsp_r;
         `SPKDG_OFS_SPREAD:   rd_mux = spread_r;
         `SPKDG_OFS_THRESH:   rd_mux = thr_r;
         `SPKDG_OFS_HEADROOM: rd_mux = head_r;
         `SPKDG_OFS_HOLD:     rd_mux = hold_r;
         `SPKDG_OFS_DELAY:    rd_mux = dly_r;
         `SPKDG_OFS_MODE:     rd_mux = mode_r;
         `SPKDG_OFS_VBAT_LVL: rd_mux = vlvl_r;
         `SPKDG_OFS_FSW:      rd_mux = fsw_r;
         `SPKDG_OFS_WB_ONLY:  rd_mux = wb_r;
         `SPKDG_OFS_EDGE1:    rd_mux = edge1_r;
         `SPKDG_OFS_EDGE2:    rd_mux = edge2_r;
         `SPKDG_OFS_CLIP:     rd_mux = clip_r;
         `SPKDG_OFS_VOLUME:   rd_mux = vol_r;
         default:             rd_mux = 8'h00;
      endcase
   end

   // read data registered one cycle after the strobe
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= REG_RD;
         if (REG_RD) rdata_r <= rd_mux;
      end
   end

   // ----------------------------------------------------------------
   // field views
   // ----------------------------------------------------------------
   wire       protect_on   = dsp_r[`SPKDG_BIT_PROTECT];
   wire       rampdn_skip  = dsp_r[`SPKDG_BIT_RAMPDN_SKIP];
   wire       rampup_skip  = dsp_r[`SPKDG_BIT_RAMPUP_SKIP];
   wire       polarity_flip = dsp_r[`SPKDG_BIT_INVERT];
   wire       dither_on    = dsp_r[`SPKDG_BIT_DITHER];
   wire       dc_block_on  = dsp_r[`SPKDG_BIT_DCBLK];
   wire [1:0] method_sel   = head_r[5:4];
   wire [1:0] supply_mode  = mode_r[1:0];
   wire       ultra_only   = wb_r[0];

   // ----------------------------------------------------------------
   // volume ramp: one 0.5dB code per sample
   // ----------------------------------------------------------------
   logic [7:0] vol_cur_r, vol_cur_nxt;
   wire  [7:0] vol_goal = AMP_ENABLE ? vol_r : `SPKDG_VOL_MUTE;
   wire        going_dn = (vol_goal > vol_cur_r);
   wire        going_up = (vol_goal < vol_cur_r);

   always_comb begin
      vol_cur_nxt = vol_cur_r;
      if (SAMPLE_STROBE) begin
         if (going_dn) vol_cur_nxt = rampdn_skip ? vol_goal : vol_cur_r + 8'h01;
         if (going_up) vol_cur_nxt = rampup_skip ? vol_goal : vol_cur_r - 8'h01;
      end
   end

   // starts muted so the first enable ramps up
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) vol_cur_r <= `SPKDG_VOL_MUTE;
      else          vol_cur_r <= vol_cur_nxt;
   end

   // ----------------------------------------------------------------
   // sample path
   // ----------------------------------------------------------------
   logic signed [AW-1:0] dc_avg_r;
   logic [15:0]          lfsr_r;
   logic signed [AW-1:0] dly_mem [DLY_DEPTH];
   logic signed [AW-1:0] out_r;
   logic                 out_vld_r;

   wire signed [AW-1:0] src = ultra_only ? WIDEBAND_SAMPLE : PCM_SAMPLE;
   wire signed [AW:0]   dc_diff = {src[AW-1], src} - {dc_avg_r[AW-1], dc_avg_r};
   wire signed [AW-1:0] after_dc = dc_block_on ? dc_diff[AW-1:0] : src;
   wire signed [AW:0]   avg_step = dc_diff >>> `SPKDG_DC_SHIFT;
   wire signed [AW:0]   avg_sum  = {dc_avg_r[AW-1], dc_avg_r} + avg_step;
   // coarse attenuation: 6dB per twelve codes, all codes inside one group of twelve give the same shift
   wire [7:0]           att_shift = vol_cur_r / `SPKDG_VOL_PER_6DB;
   wire                 muted = (vol_cur_r == `SPKDG_VOL_MUTE);
   logic signed [AW-1:0] gained;

   always_comb begin
      if (protect_on)
         gained = after_dc >>> `SPKDG_PROTECT_SHIFT;
      else if (muted)
         gained = '0;
      else
         gained = after_dc >>> att_shift;
   end

   wire signed [AW-1:0] dithered = gained + (dither_on ? AW'(lfsr_r[0]) : AW'(0));
   wire signed [AW-1:0] polar = polarity_flip ? -dithered : dithered;
   wire [5:0]           dly_n = (supply_mode == 2'h0) ? dly_r[5:0] : 6'h00;
   wire signed [AW-1:0] delayed = (dly_n == 6'h00) ? polar : dly_mem[dly_n - 6'h01];

   // sample pipeline; a stopped strobe freezes all filter state
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         dc_avg_r  <= '0;
         lfsr_r    <= 16'hace1;
         out_r     <= '0;
         out_vld_r <= 1'b0;
      end else begin
         out_vld_r <= SAMPLE_STROBE;
         if (SAMPLE_STROBE) begin
            dc_avg_r <= avg_sum[AW-1:0];
            lfsr_r   <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
            out_r    <= delayed;
         end
      end
   end

   // delay line, shifted once per sample
   always_ff @(posedge CLK_SYS) begin
      if (SAMPLE_STROBE) begin
         dly_mem[0] <= polar;
         for (int i = 1; i < DLY_DEPTH; i++) dly_mem[i] <= dly_mem[i-1];
      end
   end

   // ----------------------------------------------------------------
   // class-DG supply selection
   // ----------------------------------------------------------------
   // threshold decode: fixed level, VBAT less headroom, or the lower of the two
   wire [12:0] thr_mv   = `SPKDG_THR_TOP_MV - (`SPKDG_THR_STEP_MV * {8'h00, thr_r[4:0]});
   wire [12:0] head_mv  = `SPKDG_HEAD_STEP_MV * {9'h000, head_r[3:0]};
   wire [12:0] head_lvl = (VBAT_MV > head_mv) ? VBAT_MV - head_mv : 13'h0000;
   logic [12:0] dg_lvl;

   always_comb begin
      case (method_sel)
         2'h0:    dg_lvl = thr_mv;
         2'h1:    dg_lvl = head_lvl;
         2'h2:    dg_lvl = (thr_mv < head_lvl) ? thr_mv : head_lvl;
         default: dg_lvl = thr_mv;
      endcase
   end

   // hysteresis as a Q8 fraction of VBAT
   logic [8:0] hyst_q8;
   always_comb begin
      case (hold_r[6:4])
         3'h0:    hyst_q8 = 9'h0f2;
         3'h1:    hyst_q8 = 9'h0e4;
         3'h2:    hyst_q8 = 9'h0d7;
         3'h3:    hyst_q8 = 9'h0cb;
         3'h4:    hyst_q8 = 9'h0c0;
         3'h5:    hyst_q8 = 9'h0b5;
         3'h6:    hyst_q8 = 9'h0a2;
         default: hyst_q8 = 9'h090;
      endcase
   end
   wire [21:0] vbat_scaled = VBAT_MV * hyst_q8;
   wire        below_hyst  = ({1'b0, PEAK_MV, 8'h00} < {1'b0, vbat_scaled});
   wire        below_dg    = (PEAK_MV < dg_lvl);
   wire [12:0] floor_mv    = `SPKDG_FLOOR_BASE_MV + (`SPKDG_FLOOR_STEP_MV * {10'h000, vlvl_r[2:0]});
   wire        vbat_low    = (VBAT_MV < floor_mv);

   // hold time in microseconds, turned into cycles
   logic [19:0] hold_us;
   always_comb begin
      case (hold_r[3:0])
         4'h0:    hold_us = 20'd150;
         4'h1:    hold_us = 20'd250;
         4'h2:    hold_us = 20'd500;
         4'h3:    hold_us = 20'd1000;
         4'h4:    hold_us = 20'd2500;
         4'h5:    hold_us = 20'd5000;
         4'h6:    hold_us = 20'd10000;
         4'h7:    hold_us = 20'd20000;
         4'h8:    hold_us = 20'd30000;
         4'h9:    hold_us = 20'd40000;
         4'ha:    hold_us = 20'd50000;
         4'hb:    hold_us = 20'd125000;
         4'hc:    hold_us = 20'd250000;
         4'hd:    hold_us = 20'd500000;
         4'he:    hold_us = 20'd750000;
         default: hold_us = 20'd1000000;
      endcase
   end
   wire [27:0] hold_full   = {8'h00, hold_us} * 28'(`SPKDG_CLK_MHZ);
   wire [27:0] hold_cycles = hold_full >> HOLD_SHIFT;

   spkdg_pkg::spkdg_sup_type sup_r, sup_nxt;
   logic [27:0]              hold_cnt_r, hold_cnt_nxt;
   wire                      low_ok = below_dg && below_hyst && !vbat_low;

   always_comb begin
      sup_nxt      = sup_r;
      hold_cnt_nxt = '0;
      case (sup_r)
         spkdg_pkg::SUP_PVDD: begin
            if (low_ok) sup_nxt = spkdg_pkg::SUP_HOLD;
         end
         spkdg_pkg::SUP_HOLD: begin
            hold_cnt_nxt = hold_cnt_r + 28'h0000001;
            if (!low_ok) sup_nxt = spkdg_pkg::SUP_PVDD;
            else if (hold_cnt_r >= hold_cycles) sup_nxt = spkdg_pkg::SUP_VBAT;
         end
         spkdg_pkg::SUP_VBAT: begin
            if (!below_dg || vbat_low) sup_nxt = spkdg_pkg::SUP_PVDD;
         end
         default: sup_nxt = spkdg_pkg::SUP_PVDD;
      endcase
      if (supply_mode != 2'h0) begin
         sup_nxt      = spkdg_pkg::SUP_PVDD;
         hold_cnt_nxt = '0;
      end
   end

   wire use_vbat = (supply_mode == 2'h0) ? (sup_nxt == spkdg_pkg::SUP_VBAT) :
                   (supply_mode == 2'h2) ? (!vbat_low && below_hyst) : 1'b0;
   logic supply_vbat_r;

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         sup_r         <= spkdg_pkg::SUP_PVDD;
         hold_cnt_r    <= '0;
         supply_vbat_r <= 1'b0;
      end else begin
         sup_r         <= sup_nxt;
         hold_cnt_r    <= hold_cnt_nxt;
         supply_vbat_r <= use_vbat;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign REG_RDATA       = rdata_r;
   assign REG_RVALID      = rvalid_r;
   assign AUDIO_OUT       = out_r;
   assign AUDIO_OUT_VALID = out_vld_r;
   assign SUPPLY_VBAT     = supply_vbat_r;

   // control fields straight from the register flops
   always_comb begin
      AMP_CTRL.wide_passband_on       = dsp_r[`SPKDG_BIT_WIDE_PASS];
      AMP_CTRL.spread_clock_on        = spread_r[`SPKDG_BIT_SPREAD_ON];
      AMP_CTRL.spread_index           = spread_r[1:0];
      AMP_CTRL.double_switch_rate     = fsw_r[`SPKDG_BIT_FSW2X];
      AMP_CTRL.ultrasound_only_on     = ultra_only;
      AMP_CTRL.turnoff_slew_on        = edge1_r[`SPKDG_BIT_SLEW];
      AMP_CTRL.battery_high_side_edge = edge1_r[3:0];
      AMP_CTRL.low_side_edge          = edge2_r[7:4];
      AMP_CTRL.high_rail_edge         = edge2_r[3:0];
      // clip gain code to the clipper
      AMP_CTRL.clip_boost             = clip_r[3:0];
   end

endmodule
`default_nettype wire

// ---- verification/spkdg_check_sva.sv ----
`default_nettype none
module spkdg_check_sva #(
   parameter int AW = 24
) (
   input wire logic                 CLK_SYS,
   input wire logic                 RESET_N,
   input wire logic [15:0]          REG_ADDR,
   input wire logic                 REG_WR,
   input wire logic                 REG_RD,
   input wire logic [7:0]           REG_WDATA,
   input wire logic [7:0]           REG_RDATA,
   input wire logic                 REG_RVALID,
   input wire logic                 SAMPLE_STROBE,
   input wire logic [12:0]          VBAT_MV,
   input wire logic signed [AW-1:0] AUDIO_OUT,
   input wire logic                 AUDIO_OUT_VALID,
   input wire logic                 SUPPLY_VBAT
);
   logic [1:0]  mode_r;
   logic [12:0] floor_r;
   wire         wr_mode  = REG_WR && REG_ADDR == 16'h2098 && REG_WDATA[1:0] != 2'h3;
   wire         wr_floor = REG_WR && REG_ADDR == 16'h2099 && REG_WDATA[2:0] < 3'h6;
   // shadow of the supply fields; reserved codes are dropped just as the port drops them
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         mode_r  <= 2'h0;
         floor_r <= 13'h0af0;
      end else begin
         mode_r  <= wr_mode ? REG_WDATA[1:0] : mode_r;
         floor_r <= wr_floor ? 13'h09c4 + 13'h0064 * 13'(REG_WDATA[2:0]) : floor_r;
      end
   end
   default clocking @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESET_N);
   // register port and audio handshake
   rd_answer_a: assert property (REG_RD |=> REG_RVALID) else $error("read not answered");
   rd_cause_a: assert property (REG_RVALID |-> $past(REG_RD)) else $error("stray read valid");
   rdata_hold_a: assert property (!REG_RVALID |-> $stable(REG_RDATA)) else $error("rdata moved");
   out_answer_a: assert property (SAMPLE_STROBE |=> AUDIO_OUT_VALID) else $error("no sample out");
   out_cause_a: assert property (AUDIO_OUT_VALID |-> $past(SAMPLE_STROBE)) else $error("stray out");
   out_hold_a: assert property (!AUDIO_OUT_VALID |-> $stable(AUDIO_OUT)) else $error("out moved");
   // supply forcing
   pvdd_mode_a: assert property (mode_r == 2'h1 && $past(mode_r) == 2'h1 |-> !SUPPLY_VBAT)
      else $error("battery rail in pvdd mode");
   battery_floor_a: assert property (VBAT_MV < floor_r |=> !SUPPLY_VBAT)
      else $error("battery rail below floor");
endmodule
`default_nettype wire

// ---- verification/spkdg_host_model.sv ----
`default_nettype none
module spkdg_host_model (
   input  wire logic        clk,
   input  wire logic [7:0]  rdata,
   output logic      [15:0] addr,
   output logic             wr,
   output logic             rd,
   output logic      [7:0]  wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // bus idles quiet from time zero
   initial begin
      addr  = 16'h0000;
      wr    = 1'b0;
      rd    = 1'b0;
      wdata = 8'h00;
   end
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      addr  = a;
      wdata = d;
      wr    = 1'b1;
      @(negedge clk);
      wr    = 1'b0;
      wdata = ~d;  // released data must not look valid
   endtask
   // answer lands on the edge that takes the strobe and is read one edge later
   task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
      @(negedge clk);
      addr = a;
      rd   = 1'b1;
      @(negedge clk);
      rd   = 1'b0;
      @(posedge clk);
      #1;
      d    = rdata;
   endtask
endmodule
`default_nettype wire

// ---- verification/speaker_path_dg_control_test.sv ----
`default_nettype none
module speaker_path_dg_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, reset_n, reg_wr, reg_rd, reg_rvalid, amp_enable, sample_strobe, supply_vbat;
   logic audio_out_valid;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [12:0] peak_mv, vbat_mv;
   logic signed [23:0] pcm_sample, wideband_sample, audio_out;
   spkdg_pkg::spkdg_ctrl_type amp_ctrl;
   int error_cnt = 0, total_checks = 0, cycles = 0;
   spkdg_top #(.AW(24), .HOLD_SHIFT(10), .DLY_DEPTH(33)) dut (.CLK_SYS(clk_sys),
      .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
      .AMP_ENABLE(amp_enable), .SAMPLE_STROBE(sample_strobe), .PCM_SAMPLE(pcm_sample),
      .WIDEBAND_SAMPLE(wideband_sample), .PEAK_MV(peak_mv), .VBAT_MV(vbat_mv),
      .AUDIO_OUT(audio_out), .AUDIO_OUT_VALID(audio_out_valid), .SUPPLY_VBAT(supply_vbat),
      .AMP_CTRL(amp_ctrl));
   spkdg_host_model host (.clk(clk_sys), .rdata(reg_rdata), .addr(reg_addr), .wr(reg_wr),
      .rd(reg_rd), .wdata(reg_wdata));
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // read only, so reset values are seen untouched
   task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd_reg(a, d);
      chk($sformatf("reg %h", a), 24'(e), 24'(d));
   endtask
   task automatic wrchk(input logic [15:0] a, input logic [7:0] w, input logic [7:0] e);
      host.wr_reg(a, w);
      rdchk(a, e);
   endtask
   // each strobe carries pcm x; the wideband input holds a marker value
   task automatic playn(input int n, input logic [23:0] x);
      repeat (n) begin
         @(negedge clk_sys);
         pcm_sample = x;
         sample_strobe = 1'b1;
         @(negedge clk_sys);
         sample_strobe = 1'b0;
      end
   endtask
   task automatic aud(input logic [7:0] dsp, input logic [7:0] vol, input int n,
                      input logic [23:0] e);
      host.wr_reg(16'h2092, dsp);
      host.wr_reg(16'h2090, vol);
      playn(n, 24'h0003e8);
      chk("audio_out", e, audio_out);
   endtask
   // bounded wait for the rail, then a settle window so a wrong switch still shows
   task automatic sup(input logic e);
      for (int i = 0; i < 30 && supply_vbat !== e; i++) @(negedge clk_sys);
      repeat (10) @(negedge clk_sys);
      chk("supply_vbat", 24'(e), 24'(supply_vbat));
   endtask
   task automatic t_reset;
      logic [7:0] rv [15] = '{8'h00, 8'h00, 8'h23, 8'h08, 8'h12, 8'h17, 8'h17, 8'h00,
                             8'h00, 8'h03, 8'h00, 8'h00, 8'h03, 8'hfc, 8'h00};
      for (int i = 0; i < 15; i++) rdchk(16'h2090 + 16'(i), rv[i]);
      chk("edges", 24'h000fc3, 24'({amp_ctrl.turnoff_slew_on, amp_ctrl.low_side_edge,
          amp_ctrl.high_rail_edge, amp_ctrl.battery_high_side_edge}));
      wrchk(16'h209f, 8'hff, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_ctrl;
      for (int i = 0; i < 4; i++) begin
         host.wr_reg(16'h2093, 8'h08 | 8'(i));
         chk("spread_index", 24'(i), 24'(amp_ctrl.spread_index));
      end
      host.wr_reg(16'h2093, 8'h00);
      host.wr_reg(16'h209a, 8'h04);
      host.wr_reg(16'h209b, 8'h01);
      host.wr_reg(16'h209c, 8'h85);
      host.wr_reg(16'h209d, 8'h5a);
      host.wr_reg(16'h2092, 8'h40);
      wrchk(16'h209e, 8'h0a, 8'h0a);
      wrchk(16'h209e, 8'h0b, 8'h0a);
      chk("amp_ctrl", 24'h4755aa, 24'(amp_ctrl));
      wrchk(16'h2095, 8'h3a, 8'h1a);
      wrchk(16'h2098, 8'h03, 8'h00);
      wrchk(16'h2099, 8'h06, 8'h03);
      wrchk(16'h2097, 8'h21, 8'h00);
      wrchk(16'h2097, 8'h20, 8'h20);
      host.wr_reg(16'h2095, 8'h17);
      $display("control test done");
   endtask
   task automatic t_audio;
      host.wr_reg(16'h209b, 8'h00);
      host.wr_reg(16'h2097, 8'h00);
      aud(8'h18, 8'h00, 2, 24'h0003e8);
      aud(8'h1c, 8'h00, 1, 24'hfffc18);
      aud(8'h38, 8'h00, 1, 24'h00007d);
      aud(8'h18, 8'h0c, 2, 24'h0001f4);
      aud(8'h18, 8'hff, 2, 24'h000000);
      aud(8'h18, 8'h00, 2, 24'h0003e8);
      aud(8'h08, 8'h24, 2, 24'h0003e8);
      aud(8'h08, 8'h24, 40, 24'h00007d);
      host.wr_reg(16'h209b, 8'h01);
      aud(8'h18, 8'h00, 2, 24'h000007);
      host.wr_reg(16'h209b, 8'h00);
      host.wr_reg(16'h2097, 8'h02);
      playn(1, 24'h000001);
      playn(1, 24'h000002);
      playn(1, 24'h000003);
      chk("delayed", 24'h000001, audio_out);
      host.wr_reg(16'h2097, 8'h00);
      // the running average is well above zero by now, so a live filter pulls the level down
      host.wr_reg(16'h2092, 8'h19);
      playn(1, 24'h0003e8);
      chk("dc_block", 24'h1, 24'(audio_out < 24'sd1000 && audio_out > 24'sd0));
      amp_enable = 1'b0;
      aud(8'h18, 8'h00, 2, 24'h000000);
      amp_enable = 1'b1;
      $display("audio test done");
   endtask
   task automatic t_supply;
      peak_mv = 13'd3000;
      host.wr_reg(16'h2096, 8'h10);
      sup(1'b0);
      peak_mv = 13'd100;
      sup(1'b1);
      host.wr_reg(16'h2095, 8'h07);
      peak_mv = 13'd2100;
      sup(1'b0);
      peak_mv = 13'd1900;
      sup(1'b1);
      host.wr_reg(16'h2095, 8'h27);
      vbat_mv = 13'd3500;
      sup(1'b0);
      peak_mv = 13'd100;
      host.wr_reg(16'h2096, 8'h1f);
      sup(1'b0);
      host.wr_reg(16'h2096, 8'h10);
      sup(1'b1);
      vbat_mv = 13'd2700;
      sup(1'b0);
      host.wr_reg(16'h2099, 8'h00);
      sup(1'b1);
      host.wr_reg(16'h2098, 8'h01);
      sup(1'b0);
      vbat_mv = 13'd4000;
      peak_mv = 13'd3700;
      host.wr_reg(16'h2098, 8'h02);
      sup(1'b0);
      peak_mv = 13'd3500;
      sup(1'b1);
      host.wr_reg(16'h2096, 8'h70);
      sup(1'b0);
      $display("supply test done");
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // the whole run needs under a thousand cycles; a hang is cut well past that
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         $display("ERROR timeout expected done seen hang");
         complete_run;
      end
   end
   initial begin
      reset_n = 1'b0;
      amp_enable = 1'b1;
      sample_strobe = 1'b0;
      pcm_sample = 24'h000000;
      wideband_sample = 24'h000007;
      peak_mv = 13'd100;
      vbat_mv = 13'd4000;
      repeat (4) @(negedge clk_sys);
      reset_n = 1'b1;
      t_reset;
      t_ctrl;
      t_audio;
      t_supply;
      complete_run;
   end
endmodule
bind spkdg_top spkdg_check_sva #(.AW(AW)) u_sva (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
   .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
   .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .SAMPLE_STROBE(SAMPLE_STROBE),
   .VBAT_MV(VBAT_MV), .AUDIO_OUT(AUDIO_OUT), .AUDIO_OUT_VALID(AUDIO_OUT_VALID),
   .SUPPLY_VBAT(SUPPLY_VBAT));
`default_nettype wire
